// *** dv/pdm_link_sva.sv ***
// Checker on the link between the two ends of the power-down controller
module pdm_link_sva
  import pdm_pkg::*;
(
  input wire logic                  mclk_i,
  input wire logic                  reset_i,
  input wire logic                  sleep_exec,
  input wire logic                  nmi,
  input wire logic [7:0]            ext_irq,
  input wire logic [7:0]            ext_irq_en,
  input wire logic                  usb_resume_irq,
  input wire logic                  usb_resume_en,
  input wire logic                  other_irq,
  input wire logic                  cpu_mask,
  input wire logic                  reset_pin_n,
  input wire logic                  hw_standby_pin_n,
  input wire pdm_pkg::pdm_mode_type mode,
  input wire logic                  cpu_run,
  input wire logic                  osc_run,
  input wire logic                  clk_supply,
  input wire logic                  int_exc_start,
  input wire logic                  reset_exc_start
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Pins high: only then do the rules for leaving RUN, SLEEP, SWSTBY and RESET apply
  logic pins;
  assign pins = reset_pin_n && hw_standby_pin_n;
  property p_sleep_enter;
    sleep_exec && mode == PDM_RUN && pins |=> mode inside {PDM_SLEEP, PDM_SWSTBY};
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
  property p_hwstby;
    !hw_standby_pin_n |=> mode == PDM_HWSTBY;
  endproperty
  a_hwstby: assert property (p_hwstby) else $error("standby pin ignored");
  property p_reset_pin;
    hw_standby_pin_n && !reset_pin_n |=> mode == PDM_RESET;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
  property p_reset_exit;
    mode == PDM_RESET && pins |=> mode == PDM_RUN && reset_exc_start;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("no reset exception");
  property p_sleep_wake;
    mode == PDM_SLEEP && pins && (nmi || !cpu_mask && other_irq)
      |=> mode == PDM_RUN && int_exc_start;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not ended");
  property p_sleep_hold;
    mode == PDM_SLEEP && pins && !nmi && cpu_mask |=> mode == PDM_SLEEP;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("masked wake from sleep");
  property p_sw_wake;
    mode == PDM_SWSTBY && pins && nmi |=> mode == PDM_SETTLE ##1 mode == PDM_SETTLE;
  endproperty
  a_sw_wake: assert property (p_sw_wake) else $error("no settling wait");
  property p_sw_hold;
    mode == PDM_SWSTBY && pins && !nmi && (cpu_mask
      || !(|(ext_irq & ext_irq_en)) && !(usb_resume_irq && usb_resume_en))
      |=> mode == PDM_SWSTBY;
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("standby left wrongly");
  property p_stopped;
    mode inside {PDM_SWSTBY, PDM_HWSTBY} |-> !osc_run && !clk_supply && !cpu_run;
  endproperty
  a_stopped: assert property (p_stopped) else $error("clock runs in standby");
  property p_settle;
    mode == PDM_SETTLE |-> osc_run && !clk_supply;
  endproperty
  a_settle: assert property (p_settle) else $error("clocks before settled");
  property p_settle_exit;
    $fell(mode == PDM_SETTLE) && mode == PDM_RUN |-> int_exc_start;
  endproperty
  a_settle_exit: assert property (p_settle_exit) else $error("no interrupt after wait");
  property p_pulse;
    int_exc_start |=> !int_exc_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("exception start too long");
  c_sleep: cover property (mode == PDM_SLEEP ##1 mode == PDM_RUN);
  c_settle: cover property (mode == PDM_SETTLE ##1 mode == PDM_RUN);
  c_hwstby: cover property (mode == PDM_HWSTBY ##1 mode == PDM_RESET);
endmodule

// *** dv/power_down_mode_control_test.sv ***
// Testbench joining both ends of the power-down controller
module power_down_mode_control_test;
  import pdm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, reset_i, cmd_sleep_i, cmd_wr_i, nmi_i, usb_resume_irq_i, usb_resume_en_i;
  logic other_irq_i, cpu_mask_i, reset_n_i, hw_standby_n_i;
  logic [1:0] cmd_sel_i;
  logic [7:0] cmd_wdata_i, ext_irq_i, ext_irq_en_i, rdata_o;
  logic cpu_run_o, timer_stop_o, serial_stop_o, serial_reset_o, usb_stop_o;
  logic periph_reset_o, periph_halt_o;
  int miscompares, cmp_count;
  pdm_link_if link ();
  // Short waits keep the run small
  pdm_device #(.STS_BASE_CYCLES(4), .STS_SHORT_CYCLES(2)) pdm_device_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .link(link), .timer_stop_o(timer_stop_o),
    .serial_stop_o(serial_stop_o), .serial_reset_o(serial_reset_o), .usb_stop_o(usb_stop_o),
    .periph_reset_o(periph_reset_o), .periph_halt_o(periph_halt_o));
  pdm_host #(.OSC_HOLD_CYCLES(8), .MIN_STS_CODE(3'h0)) pdm_host_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .link(link), .cmd_sleep_i(cmd_sleep_i),
    .cmd_wr_i(cmd_wr_i), .cmd_sel_i(cmd_sel_i), .cmd_wdata_i(cmd_wdata_i), .nmi_i(nmi_i),
    .ext_irq_i(ext_irq_i), .ext_irq_en_i(ext_irq_en_i), .usb_resume_irq_i(usb_resume_irq_i),
    .usb_resume_en_i(usb_resume_en_i), .other_irq_i(other_irq_i), .cpu_mask_i(cpu_mask_i),
    .reset_n_i(reset_n_i), .hw_standby_n_i(hw_standby_n_i), .rdata_o(rdata_o),
    .cpu_run_o(cpu_run_o));
  pdm_link_sva pdm_link_sva_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .sleep_exec(link.sleep_exec), .nmi(link.nmi),
    .ext_irq(link.ext_irq), .ext_irq_en(link.ext_irq_en),
    .usb_resume_irq(link.usb_resume_irq), .usb_resume_en(link.usb_resume_en),
    .other_irq(link.other_irq), .cpu_mask(link.cpu_mask), .reset_pin_n(link.reset_pin_n),
    .hw_standby_pin_n(link.hw_standby_pin_n), .mode(link.mode), .cpu_run(link.cpu_run),
    .osc_run(link.osc_run), .clk_supply(link.clk_supply),
    .int_exc_start(link.int_exc_start), .reset_exc_start(link.reset_exc_start));
  initial begin
    mclk_i = 0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic results;
    $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait; a miss ends the run
  task automatic wait_mode(input pdm_mode_type m, input int bound);
    int i;
    i = 0;
    do begin
      @(posedge mclk_i);
      #1;
      i++;
    end while (link.mode !== m && i < bound);
    if (link.mode !== m) begin
      check("mode", 8'(link.mode), 8'(m));
      results();
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge mclk_i);
    cmd_wr_i <= 1'b1;
    cmd_sel_i <= sel;
    cmd_wdata_i <= d;
    @(posedge mclk_i);
    cmd_wr_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask
  task automatic rd(input logic [1:0] sel, input logic [7:0] exp, input string what);
    @(posedge mclk_i);
    cmd_sel_i <= sel;
    repeat (4) @(posedge mclk_i);
    #1;
    check(what, rdata_o, exp);
  endtask
  task automatic sleep_go;
    @(posedge mclk_i);
    cmd_sleep_i <= 1'b1;
    @(posedge mclk_i);
    cmd_sleep_i <= 1'b0;
  endtask
  task automatic t_reset_values;
    check("mode", 8'(link.mode), 8'(PDM_RUN));
    rd(SEL_STANDBY_CONTROL, 8'h00, "standby_control");
    rd(SEL_MSTP_HIGH, 8'h3f, "mstp_high");
    rd(SEL_MSTP_LOW, 8'hff, "mstp_low");
    check("stops", 8'({timer_stop_o, serial_stop_o, usb_stop_o, serial_reset_o}), 8'hf);
    $display("test reset_values done");
  endtask
  task automatic t_module_stop;
    wr(SEL_MSTP_HIGH, 8'h00);
    rd(SEL_MSTP_HIGH, 8'h2f, "mstp_high");
    check("timer_stop", 8'(timer_stop_o), 8'h0);
    wr(SEL_MSTP_LOW, 8'h00);
    rd(SEL_MSTP_LOW, 8'h6f, "mstp_low");
    check("low stops", 8'({serial_stop_o, serial_reset_o, usb_stop_o}), 8'h0);
    wr(SEL_MSTP_LOW, 8'h80);
    check("low stops", 8'({serial_stop_o, serial_reset_o, usb_stop_o}), 8'h6);
    wr(SEL_MSTP_HIGH, 8'hd0);
    rd(SEL_MSTP_HIGH, 8'h3f, "mstp_high");
    check("timer_stop", 8'(timer_stop_o), 8'h1);
    $display("test module_stop done");
  endtask
  task automatic t_sleep;
    wr(SEL_STANDBY_CONTROL, 8'h00);
    sleep_go();
    wait_mode(PDM_SLEEP, 5);
    repeat (2) @(posedge mclk_i);
    #1;
    check("sleep outs", 8'({cpu_run_o, periph_halt_o}), 8'h0);
    @(posedge mclk_i);
    cpu_mask_i <= 1'b1;
    other_irq_i <= 1'b1;
    ext_irq_i <= 8'hff;
    repeat (5) @(posedge mclk_i);
    #1;
    check("mode", 8'(link.mode), 8'(PDM_SLEEP));
    @(posedge mclk_i);
    cpu_mask_i <= 1'b0;
    wait_mode(PDM_RUN, 5);
    other_irq_i <= 1'b0;
    ext_irq_i <= 8'h00;
    $display("test sleep done");
  endtask
  task automatic t_settle;
    logic [2:0] code;
    int n;
    int len;
    for (int c = 0; c < 8; c++) begin
      code = 3'(c);
      wr(SEL_STANDBY_CONTROL, {1'b1, code, 4'hf});
      // Reserved code is rewritten to the minimum
      code = (code == STS_RESERVED) ? 3'h0 : code;
      rd(SEL_STANDBY_CONTROL, {1'b1, code, 4'h0}, "standby_control");
      len = (code == STS_SHORT) ? 2 : 4 << code;
      sleep_go();
      wait_mode(PDM_SWSTBY, 5);
      // Halt output lags the mode by one edge
      @(posedge mclk_i);
      #1;
      check("halt", 8'({periph_halt_o, serial_reset_o}), 8'h3);
      @(posedge mclk_i);
      cpu_mask_i <= 1'b1;
      other_irq_i <= 1'b1;
      ext_irq_i[c] <= (c != 6);
      ext_irq_en_i[c] <= 1'b1;
      usb_resume_irq_i <= (c == 6);
      usb_resume_en_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      #1;
      check("mode", 8'(link.mode), 8'(PDM_SWSTBY));
      @(posedge mclk_i);
      if (c == 7) nmi_i <= 1'b1;
      else cpu_mask_i <= 1'b0;
      wait_mode(PDM_SETTLE, 3);
      n = 1;
      do begin
        @(posedge mclk_i);
        #1;
        n++;
      end while (link.mode === PDM_SETTLE && n < 300);
      check("settle cycles", 8'(n), 8'(len + 3));
      check("mode", 8'(link.mode), 8'(PDM_RUN));
      {nmi_i, cpu_mask_i, other_irq_i, ext_irq_i, usb_resume_irq_i} <= '0;
      repeat (4) @(posedge mclk_i);
      rd(SEL_STANDBY_CONTROL, {1'b0, code, 4'h0}, "standby_control");
    end
    $display("test settle done");
  endtask
  // Bit 0: software standby, bit 1: standby pin path
  task automatic t_pins;
    for (int k = 0; k < 4; k++) begin
      wr(SEL_STANDBY_CONTROL, {k[0], 3'h7, 4'h0});
      wr(SEL_MSTP_HIGH, 8'h2f);
      sleep_go();
      wait_mode(k[0] ? PDM_SWSTBY : PDM_SLEEP, 5);
      @(posedge mclk_i);
      if (k[1]) begin
        hw_standby_n_i <= 1'b0;
        wait_mode(PDM_HWSTBY, 5);
        @(posedge mclk_i);
        #1;
        check("hw resets", 8'({periph_reset_o, serial_reset_o}), 8'h3);
        @(posedge mclk_i);
        hw_standby_n_i <= 1'b1;
      end
      reset_n_i <= 1'b0;
      wait_mode(PDM_RESET, 5);
      @(posedge mclk_i);
      #1;
      check("reset outs", 8'({periph_reset_o, link.clk_supply}), 8'h3);
      @(posedge mclk_i);
      reset_n_i <= 1'b1;
      wait_mode(PDM_RUN, 40);
      rd(SEL_STANDBY_CONTROL, 8'h00, "standby_control");
      check("timer_stop", 8'(timer_stop_o), 8'h1);
    end
    $display("test pins done");
  endtask
  initial begin
    reset_i = 1'b1;
    {cmd_sleep_i, cmd_wr_i, nmi_i, usb_resume_irq_i, usb_resume_en_i} = '0;
    {other_irq_i, cpu_mask_i, cmd_sel_i, cmd_wdata_i, ext_irq_i, ext_irq_en_i} = '0;
    reset_n_i = 1'b1;
    hw_standby_n_i = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    t_reset_values();
    t_module_stop();
    t_sleep();
    t_settle();
    t_pins();
    results();
  end
endmodule

// *** verilog/pdm_device.sv ***
// Power-down mode controller: sleep, standby and module stop control
// Overview of operation
// - Sleep instruction, select 0: enter sleep
// - Sleep instruction, select 1: software standby
// - Interrupt wake from software standby clears standby-select bit
// - Enabled unmasked interrupt ends sleep
// - Reset pin low in sleep: reset state
// - Standby pin low: hardware standby
// - Software standby retains all but serial
// - Wake interrupt restarts oscillator, waits, resumes
// - Masked wake interrupt keeps software standby
// - Reset pin clears software standby immediately
// - Settling code selects wait length
// - Software picks wait above oscillator settling
// - Stop bit 1 stops, 0 releases
// - Timer, serial, USB stop bit map
// - Unnamed stop bits keep their safe values
// - Retained modules keep registers, suspend
// - Serial and hardware-standby resets initialize
// - Only stopped modules halt; sleep combines
// - Reset leaves high-speed mode, fields zero
// - Reserved standby bits stay zero
// - Stop changes act after bus cycle
// - Standby pin rise with reset low
module pdm_device #(
  parameter int STS_BASE_CYCLES  = pdm_pkg::STS_BASE_STATES,
  parameter int STS_SHORT_CYCLES = pdm_pkg::STS_SHORT_STATES
) (
  input  wire logic     mclk_i,
  input  wire logic     reset_i,
  pdm_link_if.device    link,
  output logic          timer_stop_o,
  output logic          serial_stop_o,
  output logic          serial_reset_o,
  output logic          usb_stop_o,
  output logic          periph_reset_o,
  output logic          periph_halt_o
);
  import pdm_pkg::*;

  typedef struct packed {
    pdm_mode_type mode;
    logic [7:0]   standby_control;
    logic [7:0]   module_stop_control_high;
    logic [7:0]   module_stop_control_low;
    logic [7:0]   rdata;
    logic         int_exc;
    logic         reset_exc;
    logic         settle_start;
    logic         timer_stop;
    logic         serial_stop;
    logic         serial_reset;
    logic         usb_stop;
    logic         periph_reset;
    logic         periph_halt;
  } pdm_dev_state_type;

  localparam pdm_dev_state_type DEV_RST = '{
    mode:                     PDM_RUN,
    standby_control:          STANDBY_CONTROL_RST,
    module_stop_control_high: MSTP_HIGH_RST,
    module_stop_control_low:  MSTP_LOW_RST,
    rdata:                    8'h00,
    int_exc:                  1'b0,
    reset_exc:                1'b0,
    settle_start:             1'b0,
    timer_stop:               1'b1,
    serial_stop:              1'b1,
    serial_reset:             1'b1,
    usb_stop:                 1'b1,
    periph_reset:             1'b0,
    periph_halt:              1'b0
  };

  pdm_dev_state_type cur_ff;
  pdm_dev_state_type nxt_cur;
  logic              settle_done;
  logic              sleep_wake;
  logic              standby_wake;
  logic              wake_enabled;
  logic              standby_sel;
  logic              in_standby;

  pdm_settle_timer #(
    .BASE_STATES  (STS_BASE_CYCLES),
    .SHORT_STATES (STS_SHORT_CYCLES)
  ) u_settle (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .start_i (cur_ff.settle_start),
    .code_i  (cur_ff.standby_control[STS_LSB +: 3]),
    .done_o  (settle_done)
  );

  assign wake_enabled = |(link.ext_irq & link.ext_irq_en)
                      | (link.usb_resume_irq & link.usb_resume_en);
  assign standby_wake = link.nmi | (~link.cpu_mask & wake_enabled);
  assign sleep_wake   = link.nmi | (~link.cpu_mask & (wake_enabled | link.other_irq));
  assign standby_sel  = cur_ff.standby_control[STANDBY_SELECT_BIT];

  always_comb begin
    nxt_cur              = cur_ff;
    nxt_cur.int_exc      = 1'b0;
    nxt_cur.reset_exc    = 1'b0;
    nxt_cur.settle_start = 1'b0;
    if (!link.hw_standby_pin_n) begin
      // Standby pin wins from any mode
      nxt_cur.mode = PDM_HWSTBY;
    end else if (!link.reset_pin_n) begin
      // Reset pin low enters reset state
      nxt_cur.mode = PDM_RESET;
    end else begin
      case (cur_ff.mode)
        PDM_RUN: begin
          if (link.sleep_exec) begin
            nxt_cur.mode = standby_sel ? PDM_SWSTBY : PDM_SLEEP;
          end
        end
        PDM_SLEEP: begin
          if (sleep_wake) begin
            nxt_cur.mode    = PDM_RUN;
            nxt_cur.int_exc = 1'b1;
          end
        end
        PDM_SWSTBY: begin
          // Restart oscillator and start the wait
          if (standby_wake) begin
            nxt_cur.mode         = PDM_SETTLE;
            nxt_cur.settle_start = 1'b1;
          end
        end
        PDM_SETTLE: begin
          if (settle_done) begin
            nxt_cur.mode    = PDM_RUN;
            nxt_cur.int_exc = 1'b1;
          end
        end
        PDM_RESET: begin
          nxt_cur.mode      = PDM_RUN;
          nxt_cur.reset_exc = 1'b1;
        end
        PDM_HWSTBY: begin
          nxt_cur.mode = PDM_RESET;
        end
        default: begin
          nxt_cur.mode = PDM_RESET;
        end
      endcase
    end

    // Reset and hardware standby restore defaults
    if (nxt_cur.mode == PDM_RESET || nxt_cur.mode == PDM_HWSTBY) begin
      nxt_cur.standby_control          = STANDBY_CONTROL_RST;
      nxt_cur.module_stop_control_high = MSTP_HIGH_RST;
      nxt_cur.module_stop_control_low  = MSTP_LOW_RST;
    end else if (cur_ff.mode == PDM_RUN && link.reg_wr) begin
      // Written stop bits reach the stop outputs one cycle later
      case (link.reg_sel)
        SEL_STANDBY_CONTROL: nxt_cur.standby_control = link.reg_wdata;
        SEL_MSTP_HIGH:       nxt_cur.module_stop_control_high = link.reg_wdata;
        SEL_MSTP_LOW:        nxt_cur.module_stop_control_low = link.reg_wdata;
        default:             nxt_cur.standby_control = cur_ff.standby_control;
      endcase
    end

    case (cur_ff.mode == PDM_RUN ? link.reg_sel : 2'h3)
      SEL_STANDBY_CONTROL: nxt_cur.rdata = cur_ff.standby_control;
      SEL_MSTP_HIGH:       nxt_cur.rdata = cur_ff.module_stop_control_high;
      SEL_MSTP_LOW:        nxt_cur.rdata = cur_ff.module_stop_control_low;
      default:             nxt_cur.rdata = cur_ff.rdata;
    endcase

    in_standby = (cur_ff.mode == PDM_SWSTBY) || (cur_ff.mode == PDM_SETTLE)
              || (cur_ff.mode == PDM_HWSTBY);
    // Registered one cycle after the write
    nxt_cur.timer_stop   = cur_ff.module_stop_control_high[TIMER_STOP_BIT] | in_standby;
    nxt_cur.usb_stop     = cur_ff.module_stop_control_low[USB_STOP_BIT] | in_standby;
    nxt_cur.serial_stop  = cur_ff.module_stop_control_low[SERIAL_STOP_BIT] | in_standby;
    // Serial reset in stop and standby
    nxt_cur.serial_reset = nxt_cur.serial_stop;
    // All peripherals reset in hardware standby
    nxt_cur.periph_reset = (cur_ff.mode == PDM_HWSTBY) || (cur_ff.mode == PDM_RESET);
    nxt_cur.periph_halt  = in_standby;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= DEV_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.reg_rdata       = cur_ff.rdata;
  assign link.mode            = cur_ff.mode;
  assign link.cpu_run         = (cur_ff.mode == PDM_RUN);
  assign link.osc_run         = ~(cur_ff.mode == PDM_SWSTBY || cur_ff.mode == PDM_HWSTBY);
  // Clocks gated while the oscillator settles
  assign link.clk_supply      = (cur_ff.mode == PDM_RUN) || (cur_ff.mode == PDM_SLEEP)
                             || (cur_ff.mode == PDM_RESET);
  assign link.int_exc_start   = cur_ff.int_exc;
  assign link.reset_exc_start = cur_ff.reset_exc;
  assign timer_stop_o         = cur_ff.timer_stop;
  assign serial_stop_o        = cur_ff.serial_stop;
  assign serial_reset_o       = cur_ff.serial_reset;
  assign usb_stop_o           = cur_ff.usb_stop;
  assign periph_reset_o       = cur_ff.periph_reset;
  assign periph_halt_o        = cur_ff.periph_halt;
endmodule

// *** verilog/pdm_host.sv ***
// CPU and pin side of the power-down controller link
module pdm_host #(
  parameter int          OSC_HOLD_CYCLES = pdm_pkg::OSC_HOLD_STATES,
  parameter logic [2:0]  MIN_STS_CODE    = 3'h0
) (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  pdm_link_if.host        link,
  input  wire logic       cmd_sleep_i,
  input  wire logic       cmd_wr_i,
  input  wire logic [1:0] cmd_sel_i,
  input  wire logic [7:0] cmd_wdata_i,
  input  wire logic       nmi_i,
  input  wire logic [7:0] ext_irq_i,
  input  wire logic [7:0] ext_irq_en_i,
  input  wire logic       usb_resume_irq_i,
  input  wire logic       usb_resume_en_i,
  input  wire logic       other_irq_i,
  input  wire logic       cpu_mask_i,
  input  wire logic       reset_n_i,
  input  wire logic       hw_standby_n_i,
  output logic [7:0]      rdata_o,
  output logic            cpu_run_o
);
  import pdm_pkg::*;

  typedef struct packed {
    logic              sleep;
    logic              wr;
    logic [1:0]        sel;
    logic [7:0]        wdata;
    logic [7:0]        sts_shadow;
    logic              clear_pend;
    logic              was_settle;
    logic [HOLD_W-1:0] hold;
    logic              reset_n;
    logic              hw_standby_pin_n_n;
    logic [7:0]        rdata;
    logic              cpu_run;
  } pdm_host_state_type;

  pdm_host_state_type cur_ff;
  pdm_host_state_type nxt_cur;

  function automatic logic [7:0] legal_value(input logic [1:0] sel, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    case (sel)
      SEL_STANDBY_CONTROL: begin
        v = d & ~STANDBY_RSVD_MASK;
        // Reserved and below-minimum codes become MIN_STS_CODE; short code kept
        if (d[STS_LSB +: 3] == STS_RESERVED
            || (d[STS_LSB +: 3] < MIN_STS_CODE && d[STS_LSB +: 3] != STS_SHORT)) begin
          v[STS_LSB +: 3] = MIN_STS_CODE;
        end
      end
      SEL_MSTP_HIGH: v = (d & ~MSTP_HIGH_FORCE0) | MSTP_HIGH_FORCE1;
      SEL_MSTP_LOW:  v = d | MSTP_LOW_FORCE1;
      default:       v = d;
    endcase
    return v;
  endfunction

  always_comb begin
    nxt_cur         = cur_ff;
    nxt_cur.sleep   = cmd_sleep_i & link.cpu_run;
    nxt_cur.wr      = 1'b0;
    nxt_cur.rdata   = link.reg_rdata;
    nxt_cur.cpu_run = link.cpu_run;
    nxt_cur.hw_standby_pin_n_n  = hw_standby_n_i;
    nxt_cur.sel     = cmd_sel_i;
    // Wake pulse lands in RUN, so remember the settle phase
    nxt_cur.was_settle = (link.mode == PDM_SETTLE);
    if (link.int_exc_start && cur_ff.was_settle) begin
      nxt_cur.clear_pend = 1'b1;
    end
    if (link.cpu_run && cmd_wr_i) begin
      nxt_cur.wr    = 1'b1;
      nxt_cur.sel   = cmd_sel_i;
      nxt_cur.wdata = legal_value(cmd_sel_i, cmd_wdata_i);
      if (cmd_sel_i == SEL_STANDBY_CONTROL) begin
        nxt_cur.sts_shadow = nxt_cur.wdata;
      end
    end else if (link.cpu_run && cur_ff.clear_pend) begin
      nxt_cur.wr         = 1'b1;
      nxt_cur.sel        = SEL_STANDBY_CONTROL;
      nxt_cur.wdata      = cur_ff.sts_shadow & ~(8'h01 << STANDBY_SELECT_BIT);
      nxt_cur.sts_shadow = nxt_cur.wdata;
      nxt_cur.clear_pend = 1'b0;
    end
    if (!link.osc_run) begin
      nxt_cur.hold = HOLD_W'(OSC_HOLD_CYCLES);
    end else if (cur_ff.hold != '0) begin
      nxt_cur.hold = cur_ff.hold - HOLD_W'(1);
    end
    // Low pin is only released once the hold has run out
    nxt_cur.reset_n = reset_n_i & (cur_ff.reset_n || cur_ff.hold == '0);
    if (!reset_n_i || !hw_standby_n_i) begin
      nxt_cur.clear_pend = 1'b0;
      nxt_cur.sts_shadow = STANDBY_CONTROL_RST;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff            <= '0;
      cur_ff.sts_shadow <= STANDBY_CONTROL_RST;
      cur_ff.reset_n    <= 1'b1;
      cur_ff.hw_standby_pin_n_n     <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.sleep_exec       = cur_ff.sleep;
  assign link.reg_wr           = cur_ff.wr;
  assign link.reg_sel          = cur_ff.sel;
  assign link.reg_wdata        = cur_ff.wdata;
  assign link.nmi              = nmi_i;
  assign link.ext_irq          = ext_irq_i;
  assign link.ext_irq_en       = ext_irq_en_i;
  assign link.usb_resume_irq   = usb_resume_irq_i;
  assign link.usb_resume_en    = usb_resume_en_i;
  assign link.other_irq        = other_irq_i;
  assign link.cpu_mask         = cpu_mask_i;
  assign link.reset_pin_n      = cur_ff.reset_n;
  assign link.hw_standby_pin_n = cur_ff.hw_standby_pin_n_n;
  assign rdata_o               = cur_ff.rdata;
  assign cpu_run_o             = cur_ff.cpu_run;
endmodule

// *** verilog/pdm_link_if.sv ***
// Link between the CPU/pin side and the power-down controller
interface pdm_link_if;
  logic                 sleep_exec;
  logic                 reg_wr;
  logic [1:0]           reg_sel;
  logic [7:0]           reg_wdata;
  logic [7:0]           reg_rdata;
  logic                 nmi;
  logic [7:0]           ext_irq;
  logic [7:0]           ext_irq_en;
  logic                 usb_resume_irq;
  logic                 usb_resume_en;
  logic                 other_irq;
  logic                 cpu_mask;
  logic                 reset_pin_n;
  logic                 hw_standby_pin_n;
  pdm_pkg::pdm_mode_type mode;
  logic                 cpu_run;
  logic                 osc_run;
  logic                 clk_supply;
  logic                 int_exc_start;
  logic                 reset_exc_start;
  modport device (
    input  sleep_exec, reg_wr, reg_sel, reg_wdata, nmi, ext_irq, ext_irq_en,
    input  usb_resume_irq, usb_resume_en, other_irq, cpu_mask,
    input  reset_pin_n, hw_standby_pin_n,
    output reg_rdata, mode, cpu_run, osc_run, clk_supply, int_exc_start,
    output reset_exc_start
  );
  modport host (
    output sleep_exec, reg_wr, reg_sel, reg_wdata, nmi, ext_irq, ext_irq_en,
    output usb_resume_irq, usb_resume_en, other_irq, cpu_mask,
    output reset_pin_n, hw_standby_pin_n,
    input  reg_rdata, mode, cpu_run, osc_run, clk_supply, int_exc_start,
    input  reset_exc_start
  );
endinterface

// *** verilog/pdm_pkg.sv ***
// Shared constants and types of the power-down mode controller
package pdm_pkg;
  localparam logic [1:0] SEL_STANDBY_CONTROL = 2'h0;
  localparam logic [1:0] SEL_MSTP_HIGH       = 2'h1;
  localparam logic [1:0] SEL_MSTP_LOW        = 2'h2;
  localparam logic [7:0] STANDBY_CONTROL_RST = 8'h00;
  localparam logic [7:0] MSTP_HIGH_RST       = 8'h3f;
  localparam logic [7:0] MSTP_LOW_RST        = 8'hff;
  localparam logic [7:0] MSTP_HIGH_FORCE0    = 8'hc0;
  localparam logic [7:0] MSTP_HIGH_FORCE1    = 8'h2f;
  localparam logic [7:0] MSTP_LOW_FORCE1     = 8'h6f;
  localparam logic [7:0] STANDBY_RSVD_MASK   = 8'h0f;
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int STS_LSB            = 4;
  localparam int TIMER_STOP_BIT     = 4;
  localparam int SERIAL_STOP_BIT    = 7;
  localparam int USB_STOP_BIT       = 4;
  localparam logic [2:0] STS_RESERVED = 3'h6;
  localparam logic [2:0] STS_SHORT    = 3'h7;
  localparam int STS_BASE_STATES  = 8192;
  localparam int STS_SHORT_STATES = 16;
  localparam int OSC_HOLD_STATES  = 8192;
  localparam int SETTLE_W = 19;
  localparam int HOLD_W   = 16;
  typedef enum logic [5:0] {
    PDM_RUN    = 6'h01,
    PDM_SLEEP  = 6'h02,
    PDM_SWSTBY = 6'h04,
    PDM_SETTLE = 6'h08,
    PDM_RESET  = 6'h10,
    PDM_HWSTBY = 6'h20
  } pdm_mode_type;
endpackage

// *** verilog/pdm_settle_timer.sv ***
// Oscillation settling wait counter
module pdm_settle_timer #(
  parameter int BASE_STATES  = pdm_pkg::STS_BASE_STATES,
  parameter int SHORT_STATES = pdm_pkg::STS_SHORT_STATES
) (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       start_i,
  input  wire logic [2:0] code_i,
  output logic            done_o
);
  import pdm_pkg::*;

  typedef struct packed {
    logic                busy;
    logic                done;
    logic [SETTLE_W-1:0] count;
    logic [SETTLE_W-1:0] target;
  } pdm_settle_state_type;

  pdm_settle_state_type cur_ff;
  pdm_settle_state_type nxt_cur;

  function automatic logic [SETTLE_W-1:0] settle_target(input logic [2:0] code);
    logic [SETTLE_W-1:0] t;
    t = SETTLE_W'(BASE_STATES) << code;
    // Reserved code gets the longest wait, never a short one
    if (code == STS_RESERVED) t = SETTLE_W'(BASE_STATES) << 5;
    if (code == STS_SHORT) t = SETTLE_W'(SHORT_STATES);
    return t;
  endfunction

  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.done = 1'b0;
    if (start_i) begin
      nxt_cur.busy   = 1'b1;
      nxt_cur.count  = SETTLE_W'(1);
      nxt_cur.target = settle_target(code_i);
    end else if (cur_ff.busy) begin
      if (cur_ff.count == cur_ff.target) begin
        nxt_cur.busy = 1'b0;
        nxt_cur.done = 1'b1;
      end else begin
        nxt_cur.count = cur_ff.count + SETTLE_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign done_o = cur_ff.done;
endmodule
